// ==== hdl/ckgr_regs.sv ====
// ckgr_regs: low configuration bank with buffer and active copies.
// assumes the serial port front end decodes frames into byte accesses
// on clk_i and raises update_i as a one-cycle transfer strobe.
//
// Function
// - writes to addresses outside the map change nothing.
// - port config soft reset bits clear themselves after triggering.
// - 14-bit reference divider, low byte 0x011 resets to one.
// - 13-bit feedback divider, low 0x014 resets three, high 0x015 zero.
// - writes land in buffer bank; transfer strobe copies to active.
`timescale 1ns/1ps
module ckgr_regs #(
  parameter logic [7:0] SIL_REV_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] DEV_ID     = 8'ha5  // arbitrary value
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  srst_i,
  // serial mode, same clock domain
  input  wire logic                  i2c_mode_i,
  // register access
  input  wire ckgr_pkg::ckgr_req_s   req_i,
  input  wire logic                  update_i,
  output logic [7:0]                 rdata_o,
  output logic                       rvalid_o,
  // port control
  output logic                       soft_reset_o,
  output logic                       sdo_active_o,
  output logic                       lsb_first_o,
  // active bank
  output ckgr_pkg::ckgr_bank_s       active_o
);

  ckgr_pkg::ckgr_bank_s buf_reg, buf_next;
  ckgr_pkg::ckgr_bank_s act_reg, act_next;
  logic [7:0]           pcfg_reg, pcfg_next;
  logic                 rbsel_reg, rbsel_next;
  logic [7:0]           rdata_reg, rdata_next;
  logic                 rvalid_reg, rvalid_next;
  logic                 srst_pulse_reg, srst_pulse_next;

  // spi: fold either nibble into a symmetric pattern
  function automatic logic [7:0] mirror_cfg(input logic [7:0] d,
                                            input logic i2c);
    logic sdo;
    logic lsb;
    logic rst;
    sdo = d[ckgr_pkg::PC_SDO_LO] | d[ckgr_pkg::PC_SDO_HI];
    lsb = d[ckgr_pkg::PC_LSB_LO] | d[ckgr_pkg::PC_LSB_HI];
    rst = d[ckgr_pkg::PC_RST_LO] | d[ckgr_pkg::PC_RST_HI];
    mirror_cfg = ckgr_pkg::RST_ZERO;
    if (i2c) begin
      mirror_cfg[ckgr_pkg::PC_RST_LO] = rst;
      mirror_cfg[ckgr_pkg::PC_RST_HI] = rst;
    end else begin
      mirror_cfg[ckgr_pkg::PC_SDO_LO] = sdo;
      mirror_cfg[ckgr_pkg::PC_SDO_HI] = sdo;
      mirror_cfg[ckgr_pkg::PC_LSB_LO] = lsb;
      mirror_cfg[ckgr_pkg::PC_LSB_HI] = lsb;
      mirror_cfg[ckgr_pkg::PC_RST_LO] = rst;
      mirror_cfg[ckgr_pkg::PC_RST_HI] = rst;
    end
  endfunction

  // one source of bank defaults, so reset and soft reset cannot drift apart
  function automatic ckgr_pkg::ckgr_bank_s bank_dflt();
    bank_dflt          = '0;
    bank_dflt.pd_pump  = ckgr_pkg::RST_PD_PUMP;
    bank_dflt.ref_div  = {6'h00, ckgr_pkg::RST_REF_LO};
    bank_dflt.fb_div   = {5'h00, ckgr_pkg::RST_FB_LO};
    bank_dflt.cust_ver = {ckgr_pkg::RST_ZERO, ckgr_pkg::RST_ZERO};
  endfunction

  function automatic logic [7:0] bank_byte(input ckgr_pkg::ckgr_bank_s b,
                                           input logic [9:0] a);
    bank_byte = ckgr_pkg::RST_ZERO;
    case (a)
      ckgr_pkg::ADDR_CUST_LO: bank_byte = b.cust_ver[7:0];
      ckgr_pkg::ADDR_CUST_HI: bank_byte = b.cust_ver[15:8];
      ckgr_pkg::ADDR_PD_PUMP: bank_byte = b.pd_pump;
      ckgr_pkg::ADDR_REF_LO:  bank_byte = b.ref_div[7:0];
      ckgr_pkg::ADDR_REF_HI:  bank_byte = {2'h0, b.ref_div[13:8]};
      ckgr_pkg::ADDR_FINE_FB: bank_byte = {2'h0, b.fine_fb_div};
      ckgr_pkg::ADDR_FB_LO:   bank_byte = b.fb_div[7:0];
      ckgr_pkg::ADDR_FB_HI:   bank_byte = {3'h0, b.fb_div[12:8]};
      default:                bank_byte = ckgr_pkg::RST_ZERO;
    endcase
  endfunction

  always_comb begin
    buf_next        = buf_reg;
    act_next        = act_reg;
    pcfg_next       = pcfg_reg;
    rbsel_next      = rbsel_reg;
    srst_pulse_next = 1'b0;
    // soft reset bits drop after one cycle
    pcfg_next[ckgr_pkg::PC_RST_LO] = 1'b0;
    pcfg_next[ckgr_pkg::PC_RST_HI] = 1'b0;
    if (req_i.wr) begin
      case (req_i.addr)
        ckgr_pkg::ADDR_PORT_CFG: begin
          pcfg_next       = mirror_cfg(req_i.wdata, i2c_mode_i);
          srst_pulse_next = req_i.wdata[ckgr_pkg::PC_RST_LO] |
                            req_i.wdata[ckgr_pkg::PC_RST_HI];
        end
        ckgr_pkg::ADDR_RB_SEL:
          rbsel_next = req_i.wdata[ckgr_pkg::RB_ACTIVE_BIT];
        ckgr_pkg::ADDR_CUST_LO: buf_next.cust_ver[7:0] = req_i.wdata;
        ckgr_pkg::ADDR_CUST_HI: buf_next.cust_ver[15:8] = req_i.wdata;
        ckgr_pkg::ADDR_PD_PUMP: buf_next.pd_pump = req_i.wdata;
        ckgr_pkg::ADDR_REF_LO:  buf_next.ref_div[7:0] = req_i.wdata;
        ckgr_pkg::ADDR_REF_HI:
          buf_next.ref_div[13:8] = req_i.wdata[5:0];
        ckgr_pkg::ADDR_FINE_FB: buf_next.fine_fb_div = req_i.wdata[5:0];
        ckgr_pkg::ADDR_FB_LO:   buf_next.fb_div[7:0] = req_i.wdata;
        ckgr_pkg::ADDR_FB_HI:
          buf_next.fb_div[12:8] = req_i.wdata[4:0];
        // unused, read-only and unmapped: no state change
        default: ;
      endcase
    end
    // strobe copies what the buffer holds after this cycle's write
    if (update_i) begin
      act_next = buf_next;
    end
    // soft reset restores the bank defaults
    if (srst_pulse_reg) begin
      buf_next   = bank_dflt();
      act_next   = buf_next;
      rbsel_next = 1'b0;
      pcfg_next  = ckgr_pkg::RST_ZERO;
    end
  end

  always_comb begin
    rvalid_next = req_i.rd;
    rdata_next  = ckgr_pkg::RST_ZERO;
    case (req_i.addr)
      ckgr_pkg::ADDR_PORT_CFG: rdata_next = pcfg_reg;
      ckgr_pkg::ADDR_SIL_REV:  rdata_next = SIL_REV_ID;
      ckgr_pkg::ADDR_DEV_ID:   rdata_next = DEV_ID;
      ckgr_pkg::ADDR_RB_SEL:   rdata_next = {7'h00, rbsel_reg};
      default:
        rdata_next = rbsel_reg ? bank_byte(act_reg, req_i.addr)
                               : bank_byte(buf_reg, req_i.addr);
    endcase
    if (!req_i.rd) begin
      rdata_next = rdata_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      buf_reg        <= bank_dflt();
      act_reg        <= bank_dflt();
      pcfg_reg       <= ckgr_pkg::RST_ZERO;
      rbsel_reg      <= 1'b0;
      rdata_reg      <= ckgr_pkg::RST_ZERO;
      rvalid_reg     <= 1'b0;
      srst_pulse_reg <= 1'b0;
    end else begin
      buf_reg        <= buf_next;
      act_reg        <= act_next;
      pcfg_reg       <= pcfg_next;
      rbsel_reg      <= rbsel_next;
      rdata_reg      <= rdata_next;
      rvalid_reg     <= rvalid_next;
      srst_pulse_reg <= srst_pulse_next;
    end
  end

  assign rdata_o      = rdata_reg;
  assign rvalid_o     = rvalid_reg;
  assign soft_reset_o = srst_pulse_reg;
  assign sdo_active_o = pcfg_reg[ckgr_pkg::PC_SDO_LO];
  assign lsb_first_o  = pcfg_reg[ckgr_pkg::PC_LSB_LO];
  assign active_o     = act_reg;

  // checks
  sequence s_strobe;
    update_i && !srst_pulse_reg;
  endsequence

  // soft reset: a write with either reset bit, then a one-cycle pulse
  sequence s_rst_write;
    req_i.wr && req_i.addr == ckgr_pkg::ADDR_PORT_CFG
      && (req_i.wdata[ckgr_pkg::PC_RST_LO]
          || req_i.wdata[ckgr_pkg::PC_RST_HI]);
  endsequence

  sequence s_rst_pulse;
    soft_reset_o ##1 !soft_reset_o;
  endsequence

  bank_copy_a: assert property (@(posedge clk_i) disable iff (srst_i)
    s_strobe |=> act_reg == $past(buf_next))
    else $error("active bank not loaded on strobe");

  bank_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
    !update_i && !srst_pulse_reg |=> act_reg == $past(act_reg))
    else $error("active bank changed without strobe");

  rst_clear_a: assert property (@(posedge clk_i) disable iff (srst_i)
    s_rst_write |=> s_rst_pulse)
    else $error("soft reset did not self clear");

  spi_mirror_a: assert property (@(posedge clk_i) disable iff (srst_i)
    !$past(i2c_mode_i) |-> pcfg_reg[ckgr_pkg::PC_SDO_LO]
      == pcfg_reg[ckgr_pkg::PC_SDO_HI]
      && pcfg_reg[ckgr_pkg::PC_LSB_LO] == pcfg_reg[ckgr_pkg::PC_LSB_HI])
    else $error("port config not mirrored");

  unmapped_wr_a: assert property (@(posedge clk_i) disable iff (srst_i)
    req_i.wr && req_i.addr > ckgr_pkg::ADDR_FB_HI && !srst_pulse_reg
    |=> buf_reg == $past(buf_reg) && rbsel_reg == $past(rbsel_reg))
    else $error("unmapped write changed state");

  ref_range_a: assert property (@(posedge clk_i) disable iff (srst_i)
    req_i.wr && req_i.addr == ckgr_pkg::ADDR_REF_HI && !srst_pulse_reg
    |=> buf_reg.ref_div[13:8] == $past(req_i.wdata[5:0]))
    else $error("reference divider high byte not stored");

  fb_range_a: assert property (@(posedge clk_i) disable iff (srst_i)
    req_i.wr && req_i.addr == ckgr_pkg::ADDR_FB_LO && !srst_pulse_reg
    |=> buf_reg.fb_div[7:0] == $past(req_i.wdata))
    else $error("feedback divider low byte not stored");

  rb_sel_a: assert property (@(posedge clk_i) disable iff (srst_i)
    req_i.rd && req_i.addr == ckgr_pkg::ADDR_FB_LO
    |=> rvalid_o && rdata_o == ($past(rbsel_reg) ? $past(act_reg.fb_div[7:0])
                                : $past(buf_reg.fb_div[7:0])))
    else $error("readback bank selection wrong");

endmodule // ckgr_regs

// ==== inc/ckgr_pkg.sv ====
// ckgr_pkg: addresses, field positions and reset values for the low
// configuration register bank of the clock generator.
// assumes a byte-wide register port with 10-bit addresses.
package ckgr_pkg;

  localparam int          ADDR_W          = 10;
  localparam int          DATA_W          = 8;

  // register addresses
  localparam logic [9:0]  ADDR_PORT_CFG   = 10'h000;
  localparam logic [9:0]  ADDR_UNUSED_ONE = 10'h001;
  localparam logic [9:0]  ADDR_SIL_REV    = 10'h002;
  localparam logic [9:0]  ADDR_DEV_ID     = 10'h003;
  localparam logic [9:0]  ADDR_RB_SEL     = 10'h004;
  localparam logic [9:0]  ADDR_CUST_LO    = 10'h005;
  localparam logic [9:0]  ADDR_CUST_HI    = 10'h006;
  localparam logic [9:0]  ADDR_UNUSED_LO  = 10'h007;
  localparam logic [9:0]  ADDR_UNUSED_HI  = 10'h00f;
  localparam logic [9:0]  ADDR_PD_PUMP    = 10'h010;
  localparam logic [9:0]  ADDR_REF_LO     = 10'h011;
  localparam logic [9:0]  ADDR_REF_HI     = 10'h012;
  localparam logic [9:0]  ADDR_FINE_FB    = 10'h013;
  localparam logic [9:0]  ADDR_FB_LO      = 10'h014;
  localparam logic [9:0]  ADDR_FB_HI      = 10'h015;

  // port config field positions (mirrored nibbles)
  localparam int          PC_SDO_LO       = 0;
  localparam int          PC_LSB_LO       = 1;
  localparam int          PC_RST_LO       = 2;
  localparam int          PC_RST_HI       = 5;
  localparam int          PC_LSB_HI       = 6;
  localparam int          PC_SDO_HI       = 7;
  localparam int          RB_ACTIVE_BIT   = 0;

  // reset values
  localparam logic [7:0]  RST_ZERO        = 8'h00;
  localparam logic [7:0]  RST_REF_LO      = 8'h01;
  localparam logic [7:0]  RST_FB_LO       = 8'h03;
  localparam logic [7:0]  RST_PD_PUMP     = 8'h00;

  // field widths of the upper divider bytes
  localparam logic [7:0]  REF_HI_MASK     = 8'h3f;
  localparam logic [7:0]  FINE_FB_MASK    = 8'h3f;
  localparam logic [7:0]  FB_HI_MASK      = 8'h1f;

  // register access request, read or write
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [9:0]        addr;
    logic [7:0]        wdata;
  } ckgr_req_s;

  // control bank carried to the pll
  typedef struct packed {
    logic [7:0]        pd_pump;
    logic [13:0]       ref_div;
    logic [5:0]        fine_fb_div;
    logic [12:0]       fb_div;
    logic [15:0]       cust_ver;
  } ckgr_bank_s;

endpackage

// ==== tb/ckgr_host.sv ====
// ckgr_host: host controller model issuing byte accesses and strobes.
// assumes the bank samples req and update on the rising edge of clk_i.
`timescale 1ns/1ps
module ckgr_host (
  // clock
  input  wire logic           clk_i,
  // register access
  output ckgr_pkg::ckgr_req_s req_o,
  output logic                upd_o
);
  initial begin
    req_o = '0;
    upd_o = 1'b0;
  end
  // released lines show the inverse, not the stale value
  task automatic acc(input logic w, input logic [9:0] a,
                     input logic [7:0] d);
    @(posedge clk_i) #1;
    req_o = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_i) #1;
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic upd();
    @(posedge clk_i) #1;
    upd_o = 1'b1;
    @(posedge clk_i) #1;
    upd_o = 1'b0;
  endtask
endmodule // ckgr_host

// ==== tb/test_ckgr_regs.sv ====
// test_ckgr_regs: random accesses checked against an integer model.
// assumes ckgr_host drives the bank one cycle per access.
`timescale 1ns/1ps
module test_ckgr_regs;
  logic                 clk_i = 1'b0;
  logic                 srst_i = 1'b1;
  logic                 i2c_mode_i = 1'b0;
  ckgr_pkg::ckgr_req_s  req;
  logic                 upd;
  logic [7:0]           rdata_o;
  logic                 rvalid_o, soft_reset_o, sdo_active_o, lsb_first_o;
  ckgr_pkg::ckgr_bank_s active_o;
  int bm[0:21], am[0:21], pc, n_fail, checks_done, a, d, op;
  int seed = 55;
  logic [7:0] pcv[5] = '{8'h01, 8'h40, 8'h80, 8'h02, 8'h00};
  always #2 clk_i = ~clk_i;
  ckgr_host host (.clk_i(clk_i), .req_o(req), .upd_o(upd));
  ckgr_regs dut (.clk_i(clk_i), .srst_i(srst_i), .i2c_mode_i(i2c_mode_i),
    .req_i(req), .update_i(upd), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .soft_reset_o(soft_reset_o), .sdo_active_o(sdo_active_o),
    .lsb_first_o(lsb_first_o), .active_o(active_o));
  function automatic int msk(int x);
    case (x)
      4: return 1;
      5, 6, 16, 17, 20: return 255;
      18, 19: return 63;
      21: return 31;
      default: return 0;
    endcase
  endfunction
  function automatic void mrst();
    foreach (bm[i]) bm[i] = 0;
    bm[17] = 1;
    bm[20] = 3;
    am = bm;
    pc = 0;
  endfunction
  function automatic int erd(int x);
    if (x == 0) return pc;
    if (x == 2) return 'h5a;
    if (x == 3) return 'ha5;
    if (x == 4) return bm[4];
    if (x < 22 && msk(x) != 0) return bm[4] ? am[x] : bm[x];
    return 0;
  endfunction
  function automatic ckgr_pkg::ckgr_bank_s eb();
    eb.pd_pump     = am[16][7:0];
    eb.ref_div     = {am[18][5:0], am[17][7:0]};
    eb.fine_fb_div = am[19][5:0];
    eb.fb_div      = {am[21][4:0], am[20][7:0]};
    eb.cust_ver    = {am[6][7:0], am[5][7:0]};
  endfunction
  task automatic bad(input string m);
    n_fail++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic chk_bit(input logic g, input logic e);
    checks_done++;
    if (g !== e) bad("flag mismatch");
  endtask
  task automatic chk_rd(input int x);
    checks_done++;
    if (rvalid_o !== 1'b1 || rdata_o !== 8'(erd(x))) bad("read mismatch");
  endtask
  task automatic chk_bank();
    checks_done++;
    if (active_o !== eb()) bad("active bank mismatch");
  endtask
  task automatic rdc(input int x);
    host.acc(1'b0, 10'(x), 8'h00);
    chk_rd(x);
  endtask
  task automatic give_verdict();
    $display("mismatches %0d checks %0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    bad("run limit reached");
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    #1 srst_i = 1'b0;
    mrst();
    chk_bank();
    for (int i = 0; i < 24; i++) rdc(i);
    repeat (300) begin
      op = $random(seed) & 3;
      a = $random(seed) & 'h1f;
      d = $random(seed) & 'hff;
      if (a == 0) a = 'h3ff;
      if (a == 1 || (a >= 7 && a <= 15)) d = 0;
      if (op < 2) begin
        host.acc(1'b1, 10'(a), 8'(d));
        if (a < 22 && msk(a) != 0) bm[a] = d & msk(a);
      end else if (op == 2) begin
        rdc(a);
      end else begin
        host.upd();
        am = bm;
        chk_bank();
      end
    end
    foreach (pcv[i]) begin
      d = pcv[i];
      host.acc(1'b1, 10'h000, 8'(d));
      pc = ((d & 'h81) != 0 ? 'h81 : 0) | ((d & 'h42) != 0 ? 'h42 : 0);
      rdc(0);
      chk_bit(sdo_active_o, pc[0]);
      chk_bit(lsb_first_o, pc[1]);
    end
    for (int m = 0; m < 2; m++) begin
      i2c_mode_i = 1'(m);
      host.acc(1'b1, 10'h014, 8'h07);
      host.upd();
      host.acc(1'b1, 10'h000, m ? 8'h04 : 8'h20);
      chk_bit(soft_reset_o, 1'b1);
      @(posedge clk_i) #1;
      chk_bit(soft_reset_o, 1'b0);
      mrst();
      chk_bank();
      rdc(0);
    end
    give_verdict();
  end
endmodule // test_ckgr_regs
